// ### pmcm_far_model.sv
// far side stand-in: wake sources, pad levels and slow clock sources
// assumes the bench calls its tasks; all changes land at the falling edge
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// wake pins and slow sources
// ----------------------------------------
module pmcm_far_model #(
  parameter int IO_W = 26
) (
  // clock
  input wire logic clk_sys_i,
  // far side levels
  output pmcm_pkg::pmcm_wake_type wake_o,
  output logic [IO_W-1:0] pin_level_o,
  output logic [2:0] slow_src_o
);
  import pmcm_pkg::*;
  logic [3:0] div;
  // idle levels at time zero
  initial begin
    div = 4'h0;
    wake_o = '0;
    pin_level_o = '0;
  end
  // slow sources run free at distinct rates
  always @(negedge clk_sys_i) begin
    div <= div + 4'h1;
  end
  assign slow_src_o = div[3:1];
  // one-cycle wake pulse on bit b
  task automatic wake(input int b);
    @(negedge clk_sys_i);
    wake_o[b] = 1'b1;
    @(negedge clk_sys_i);
    wake_o = '0;
  endtask
  // pad level change on bit b
  task automatic flip(input int b);
    @(negedge clk_sys_i);
    pin_level_o[b] = ~pin_level_o[b];
  endtask
endmodule
`default_nettype wire

// ### pmcm_pkg.sv
// package for the power mode and clock manager: modes, reset causes, carriers
// assumes a single 40 MHz system clock domain
package pmcm_pkg;

  // power mode encodings (one-hot)
  typedef enum logic [5:0] {
    PMCM_ST_ACTIVE   = 6'h01,
    PMCM_ST_IDLE     = 6'h02,
    PMCM_ST_CLKSTOP  = 6'h04,
    PMCM_ST_STANDBY  = 6'h08,
    PMCM_ST_SHUTDOWN = 6'h10,
    PMCM_ST_WAKERST  = 6'h20
  } pmcm_state_type;

  // software mode requests
  typedef enum logic [1:0] {
    PMCM_REQ_ACTIVE   = 2'h0,
    PMCM_REQ_IDLE     = 2'h1,
    PMCM_REQ_STANDBY  = 2'h2,
    PMCM_REQ_SHUTDOWN = 2'h3
  } pmcm_req_type;

  // slow clock source selection
  typedef enum logic [1:0] {
    PMCM_LF_RC     = 2'h0,
    PMCM_LF_XTAL   = 2'h1,
    PMCM_LF_BYPASS = 2'h2
  } pmcm_lfsel_type;

  // reset cause codes
  localparam logic [2:0] PMCM_CAUSE_POR     = 3'h1;
  localparam logic [2:0] PMCM_CAUSE_PIN     = 3'h2;
  localparam logic [2:0] PMCM_CAUSE_SDWAKE  = 3'h3;
  localparam logic [2:0] PMCM_CAUSE_THERMAL = 3'h4;

  // timing
  localparam int PMCM_CLK_HZ = 40000000;
  localparam int PMCM_CLKSTOP_NS = 100;
  localparam int PMCM_CLKSTOP_CYC = (PMCM_CLKSTOP_NS * (PMCM_CLK_HZ / 1000000) + 999) / 1000;
  localparam int PMCM_WAKERST_NS = 200;
  localparam int PMCM_WAKERST_CYC = (PMCM_WAKERST_NS * (PMCM_CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [3:0] PMCM_CNT_RST = 4'h0;

  // domain and clock enables to the rest of the chip
  typedef struct packed {
    logic mcu_domain_on;
    logic always_on_domain_on;
    logic cpu_run;
    logic flash_on;
    logic sram_on;
    logic sram_retain;
    logic infra_clk_on;
    logic main_system_clock_on;
    logic supply_duty_cycled;
  } pmcm_power_type;

  // peripheral enables
  typedef struct packed {
    logic radio_en;
    logic io_controller_en;
    logic battery_temp_monitor_en;
    logic rtc_en;
    logic low_power_comparator_en;
    logic watchdog_timer_en;
    logic brownout_detector_on;
    logic periph_clk_gate_en;
  } pmcm_periph_type;

  // wake sources
  typedef struct packed {
    logic pin_edge;
    logic rtc_event;
    logic comparator_event;
    logic reset_pin;
  } pmcm_wake_type;

  localparam pmcm_power_type PMCM_POWER_RST = '0;
  localparam pmcm_periph_type PMCM_PERIPH_RST = '0;

endpackage

// ### pmcm_sva.sv
// checker for the power mode and clock manager, bound to pmcm_top
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// mode sequencing checks
// ----------------------------------------
module pmcm_sva (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // watched inputs
  input wire logic mode_req_valid_i,
  input wire logic bus_busy_i,
  input wire logic dma_busy_i,
  input wire pmcm_pkg::pmcm_wake_type wake_i,
  // watched outputs
  input wire logic mode_req_ack_o,
  input wire pmcm_pkg::pmcm_state_type mode_o,
  input wire pmcm_pkg::pmcm_power_type power_o,
  input wire logic sys_reset_o
);
  import pmcm_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // clock held stopped for the whole stop phase
  sequence s_clk_stopped;
    (mode_o == PMCM_ST_CLKSTOP && !power_o.main_system_clock_on)[*4];
  endsequence
  // domain off only once clocks are down
  sequence s_domain_off;
    (mode_o == PMCM_ST_STANDBY || mode_o == PMCM_ST_SHUTDOWN) && !power_o.mcu_domain_on;
  endsequence
  // reset held through the wake-reset phase
  sequence s_reset_held;
    (mode_o == PMCM_ST_WAKERST && sys_reset_o)[*8];
  endsequence
  chk_ack_when_free: assert property ($rose(mode_req_ack_o) |->
    $past(mode_req_valid_i && !bus_busy_i && !dma_busy_i)) else $error("ack without a free request");
  chk_ack_one_pulse: assert property (mode_req_ack_o |=> !mode_req_ack_o)
    else $error("ack longer than one cycle");
  chk_stop_before_off: assert property ($rose(mode_o == PMCM_ST_CLKSTOP) |->
    s_clk_stopped ##1 s_domain_off) else $error("clock stop order broken");
  chk_wake_reset_len: assert property ($rose(mode_o == PMCM_ST_WAKERST) |->
    s_reset_held ##1 (mode_o == PMCM_ST_ACTIVE && !sys_reset_o)) else $error("wake reset length wrong");
  chk_standby_power: assert property (mode_o == PMCM_ST_STANDBY |-> !power_o.mcu_domain_on &&
    power_o.always_on_domain_on && !power_o.main_system_clock_on && power_o.sram_retain &&
    power_o.supply_duty_cycled) else $error("standby power map wrong");
  chk_active_power: assert property (mode_o == PMCM_ST_ACTIVE && !$past(rst_i) |->
    power_o.mcu_domain_on && power_o.always_on_domain_on && power_o.cpu_run && power_o.flash_on &&
    power_o.sram_on) else $error("active power map wrong");
  chk_shutdown_all_off: assert property (mode_o == PMCM_ST_SHUTDOWN |-> power_o == PMCM_POWER_RST)
    else $error("shutdown left power on");
  chk_standby_wake_exit: assert property (mode_o == PMCM_ST_STANDBY && wake_i != '0 |->
    ##[1:2] mode_o == PMCM_ST_ACTIVE) else $error("standby wake missed");
endmodule
bind pmcm_top pmcm_sva i_pmcm_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .mode_req_valid_i(mode_req_valid_i), .bus_busy_i(bus_busy_i), .dma_busy_i(dma_busy_i),
  .wake_i(wake_i), .mode_req_ack_o(mode_req_ack_o), .mode_o(mode_o), .power_o(power_o),
  .sys_reset_o(sys_reset_o));
`default_nettype wire

// ### pmcm_top.sv
// power mode and clock manager: mode sequencing, io latching, reset cause
// assumes all inputs synchronous to clk_sys_i; software requests held until ack
// Operation
// - active mode powers mcu and always-on domains, cpu runs, flash and sram on
// - peripheral clock gating follows cpu request only, never automatic
// - idle sleeps cpu; infra clocks gated only if dma and debug allow
// - standby keeps only always-on domain, stops fast clock, retains sram
// - standby exits to active on pin, rtc or comparator wake
// - reset pin in standby returns device to active
// - standby wake resumes execution without reset or reconfiguration
// - all gpio outputs held latched during standby
// - shutdown powers everything off, holding io at pre-entry value
// - level change on shutdown wake pin wakes via reset sequence
// - reset cause distinguishes shutdown wake, pin reset, power-on, thermal
// - only latched io, 3v bank and flash survive shutdown
// - standby peripherals limited to io controller, battery monitor, rtc, comparator, watchdog
// - always-on functions forced; available ones follow software enable
// - main clock is 40 MHz rc oscillator, optionally tracking crystal
// - radio allowed only with fast crystal reference present and used
// - slow clock feeds rtc and watchdog in standby, resyncs radio timer
// - slow clock selectable: rc, crystal or bypass input
// - slow clock output allowed only from crystal or rc source
// - rtc counter cleared on reset or shutdown
`timescale 1ns/1ps
`default_nettype none

module pmcm_top #(
  parameter int IO_W = 26,
  parameter int BANK_W = 32
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // reset sources
  input wire logic por_i,
  input wire logic thermal_rst_i,
  // software mode request
  input wire logic mode_req_valid_i,
  input wire pmcm_pkg::pmcm_req_type mode_req_i,
  input wire logic bus_busy_i,
  input wire logic dma_busy_i,
  input wire logic debug_busy_i,
  // software enables
  input wire pmcm_pkg::pmcm_periph_type sw_periph_en_i,
  input wire logic sw_periph_gate_i,
  input wire logic lf_out_en_i,
  input wire pmcm_pkg::pmcm_lfsel_type lf_sel_i,
  input wire logic fast_xtal_track_i,
  input wire logic fast_crystal_reference_ok_i,
  // wake and pins
  input wire pmcm_pkg::pmcm_wake_type wake_i,
  input wire logic [IO_W-1:0] sd_wake_mask_i,
  input wire logic [IO_W-1:0] pin_level_i,
  input wire logic [IO_W-1:0] gpio_out_i,
  input wire logic [IO_W-1:0] gpio_oe_n_i,
  // 3v bank write
  input wire logic bank_we_i,
  input wire logic [BANK_W-1:0] bank_wdata_i,
  // slow clock source levels
  input wire logic slow_rc_oscillator_i,
  input wire logic slow_crystal_source_i,
  input wire logic slow_bypass_i,
  // outputs
  output logic mode_req_ack_o,
  output pmcm_pkg::pmcm_state_type mode_o,
  output pmcm_pkg::pmcm_power_type power_o,
  output pmcm_pkg::pmcm_periph_type periph_o,
  output logic main_system_clock_xtal_o,
  output logic slow_system_clock_o,
  output logic slow_clk_pin_o,
  output logic slow_clk_pin_oe_n_o,
  output logic rtc_clear_o,
  output logic sys_reset_o,
  output logic [2:0] reset_cause_o,
  output logic [IO_W-1:0] pad_out_o,
  output logic [IO_W-1:0] pad_oe_n_o,
  output logic [BANK_W-1:0] bank_o
);
  import pmcm_pkg::*;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // modes with the always-on domain gone: slow clock dead, pads frozen
  function automatic logic is_dark(input pmcm_state_type s);
    return (s == PMCM_ST_SHUTDOWN) || (s == PMCM_ST_WAKERST);
  endfunction

  // modes past the clock stop that still keep the always-on domain alive
  function automatic logic keeps_aon(input pmcm_state_type s);
    return (s == PMCM_ST_CLKSTOP) || (s == PMCM_ST_STANDBY);
  endfunction

  // ------------------------------------------------------------
  // state and sequencing
  // ------------------------------------------------------------
  // mode register, captured target, phase counter and wake reference
  pmcm_state_type state;
  pmcm_state_type next_state;
  pmcm_req_type target;
  logic [3:0] cnt;
  logic [IO_W-1:0] pin_ref;

  // request qualification: a request only lands in active mode with the
  // bus and dma quiet, otherwise it simply waits with no indication
  wire quiet = !bus_busy_i && !dma_busy_i;
  wire take_req = mode_req_valid_i && quiet && (state == PMCM_ST_ACTIVE);
  wire go_low = take_req && (mode_req_i == PMCM_REQ_STANDBY || mode_req_i == PMCM_REQ_SHUTDOWN);
  wire std_wake = wake_i.pin_edge || wake_i.rtc_event || wake_i.comparator_event;
  wire sd_wake = |((pin_level_i ^ pin_ref) & sd_wake_mask_i);
  wire cnt_done = (cnt == 4'(PMCM_CLKSTOP_CYC - 1));
  wire rst_done = (cnt == 4'(PMCM_WAKERST_CYC - 1));
  // the reset pin also ends idle, so the cpu never sits asleep under a reset
  wire idle_wake = std_wake || wake_i.reset_pin || (mode_req_valid_i && mode_req_i == PMCM_REQ_ACTIVE);

  // next mode
  // standby and shutdown always pass through the clock-stop phase so the
  // fast clock is down before any domain loses power
  always_comb begin
    next_state = state;
    case (state)
      PMCM_ST_ACTIVE: begin
        if (go_low) begin
          next_state = PMCM_ST_CLKSTOP;
        end else if (take_req && mode_req_i == PMCM_REQ_IDLE) begin
          next_state = PMCM_ST_IDLE;
        end
      end
      PMCM_ST_IDLE: begin
        if (idle_wake) begin
          next_state = PMCM_ST_ACTIVE;
        end
      end
      PMCM_ST_CLKSTOP: begin
        if (cnt_done) begin
          next_state = (target == PMCM_REQ_SHUTDOWN) ? PMCM_ST_SHUTDOWN : PMCM_ST_STANDBY;
        end
      end
      PMCM_ST_STANDBY: begin
        if (std_wake || wake_i.reset_pin) begin
          next_state = PMCM_ST_ACTIVE;
        end
      end
      PMCM_ST_SHUTDOWN: begin
        if (sd_wake || wake_i.reset_pin) begin
          next_state = PMCM_ST_WAKERST;
        end
      end
      PMCM_ST_WAKERST: begin
        if (rst_done) begin
          next_state = PMCM_ST_ACTIVE;
        end
      end
      default: next_state = PMCM_ST_ACTIVE;
    endcase
  end

  // mode register
  // power-on and thermal resets force active mode at once, from any mode
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || por_i || thermal_rst_i) begin
      state <= PMCM_ST_ACTIVE;
    end else begin
      state <= next_state;
    end
  end

  // captured target and stage counter
  // the counter restarts on every mode change, so each timed phase counts
  // from zero; the target is captured only when a low-power request lands
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      target <= PMCM_REQ_ACTIVE;
      cnt <= PMCM_CNT_RST;
    end else begin
      if (go_low) begin
        target <= mode_req_i;
      end
      cnt <= (next_state != state) ? PMCM_CNT_RST : cnt + 4'h1;
    end
  end

  // request acknowledge, one cycle
  // software drops its request on seeing this pulse; a request still held
  // after a mode change is not taken again outside active mode
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_req_ack_o <= 1'b0;
    end else begin
      mode_req_ack_o <= take_req;
    end
  end

  // ------------------------------------------------------------
  // domain power and peripheral enables
  // ------------------------------------------------------------
  // one-hot mode decodes shared by the maps below
  wire s_act = (state == PMCM_ST_ACTIVE);
  wire s_idle = (state == PMCM_ST_IDLE);
  wire s_stop = (state == PMCM_ST_CLKSTOP);
  wire s_stby = (state == PMCM_ST_STANDBY);
  wire run = s_act || s_idle;
  wire use_xtal = fast_xtal_track_i && fast_crystal_reference_ok_i;
  pmcm_power_type next_power;
  pmcm_periph_type next_periph;

  // power map per mode
  // enables are registered, so every map lags the mode register by one
  // cycle and lines up with mode_o
  always_comb begin
    next_power = PMCM_POWER_RST;
    next_power.mcu_domain_on = run || s_stop;
    next_power.always_on_domain_on = run || keeps_aon(state);
    next_power.cpu_run = s_act;
    next_power.flash_on = s_act || (s_idle && (dma_busy_i || debug_busy_i));
    next_power.sram_on = run;
    next_power.sram_retain = run || keeps_aon(state);
    next_power.infra_clk_on = s_act || (s_idle && (dma_busy_i || debug_busy_i));
    next_power.main_system_clock_on = run;
    next_power.supply_duty_cycled = s_stby;
  end

  // peripheral map: on forced, available follows software
  // standby forces the io controller on; the other standby peripherals
  // still wait for their software enable
  always_comb begin
    next_periph = PMCM_PERIPH_RST;
    next_periph.radio_en = run && sw_periph_en_i.radio_en && use_xtal;
    next_periph.io_controller_en = (run && sw_periph_en_i.io_controller_en) || s_stby;
    next_periph.battery_temp_monitor_en = (run || s_stby) && sw_periph_en_i.battery_temp_monitor_en;
    next_periph.rtc_en = (run || s_stby) && sw_periph_en_i.rtc_en;
    next_periph.low_power_comparator_en = (run || s_stby) && sw_periph_en_i.low_power_comparator_en;
    next_periph.watchdog_timer_en = (run || s_stby) && sw_periph_en_i.watchdog_timer_en;
    next_periph.brownout_detector_on = run || keeps_aon(state);
    next_periph.periph_clk_gate_en = run && sw_periph_gate_i;
  end

  // registered enables
  // crystal tracking is reported only while the fast clock runs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      power_o <= PMCM_POWER_RST;
      periph_o <= PMCM_PERIPH_RST;
      mode_o <= PMCM_ST_ACTIVE;
      main_system_clock_xtal_o <= 1'b0;
    end else begin
      power_o <= next_power;
      periph_o <= next_periph;
      mode_o <= state;
      main_system_clock_xtal_o <= run && use_xtal;
    end
  end

  // ------------------------------------------------------------
  // slow clock selection and output
  // ------------------------------------------------------------
  // source select and the modes that keep a slow clock
  wire lf_mux = (lf_sel_i == PMCM_LF_XTAL) ? slow_crystal_source_i :
                (lf_sel_i == PMCM_LF_BYPASS) ? slow_bypass_i : slow_rc_oscillator_i;
  wire lf_live = !is_dark(state);
  wire lf_pin_ok = lf_out_en_i && (lf_sel_i != PMCM_LF_BYPASS) && lf_live;

  // slow clock and its pin
  // the sources are taken as levels; a bypass input is never echoed on the
  // pin, which would just loop an outside clock back out
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      slow_system_clock_o <= 1'b0;
      slow_clk_pin_o <= 1'b0;
      slow_clk_pin_oe_n_o <= 1'b1;
    end else begin
      slow_system_clock_o <= lf_mux && lf_live;
      slow_clk_pin_o <= lf_mux && lf_pin_ok;
      slow_clk_pin_oe_n_o <= !lf_pin_ok;
    end
  end

  // ------------------------------------------------------------
  // io latching, 3v bank, reset cause
  // ------------------------------------------------------------
  wire io_hold = is_dark(state) || keeps_aon(state);

  // pad latch: frozen from clock stop until active again
  // freezing from the clock stop on keeps the pads from following a core
  // that is already winding down
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pad_out_o <= '0;
      pad_oe_n_o <= '1;
    end else if (!io_hold) begin
      pad_out_o <= gpio_out_i;
      pad_oe_n_o <= gpio_oe_n_i;
    end
  end

  // pin reference for shutdown wake, taken at entry
  // any masked pin that differs from this reference wakes the device, so a
  // level change in either direction counts
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_ref <= '0;
    end else if (state != PMCM_ST_SHUTDOWN) begin
      pin_ref <= pin_level_i;
    end
  end

  // 3v bank survives shutdown and wake reset
  // writes are only honoured in active mode, never while powering down
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      bank_o <= '0;
    end else if (bank_we_i && s_act) begin
      bank_o <= bank_wdata_i;
    end
  end

  // reset cause and system reset
  // the cause is held until the next reset source; a power-on outranks a
  // thermal reset, which outranks any pin event
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reset_cause_o <= PMCM_CAUSE_POR;
      sys_reset_o <= 1'b1;
      rtc_clear_o <= 1'b1;
    end else begin
      if (por_i) begin
        reset_cause_o <= PMCM_CAUSE_POR;
      end else if (thermal_rst_i) begin
        reset_cause_o <= PMCM_CAUSE_THERMAL;
      end else if (state == PMCM_ST_SHUTDOWN && wake_i.reset_pin) begin
        reset_cause_o <= PMCM_CAUSE_PIN;
      end else if (state == PMCM_ST_SHUTDOWN && sd_wake) begin
        reset_cause_o <= PMCM_CAUSE_SDWAKE;
      end else if (run && wake_i.reset_pin) begin
        reset_cause_o <= PMCM_CAUSE_PIN;
      end
      sys_reset_o <= por_i || thermal_rst_i || (state == PMCM_ST_WAKERST) ||
                     (run && wake_i.reset_pin);
      rtc_clear_o <= por_i || thermal_rst_i || !lf_live || (run && wake_i.reset_pin);
    end
  end

endmodule

`default_nettype wire

// ### tb_top.sv
// self-checking bench for the power mode and clock manager
// assumes the far-side model and the bound checker
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench
// ----------------------------------------
module tb_top;
  import pmcm_pkg::*;
  logic clk_sys_i, rst_i, por_i, thermal_rst_i, mode_req_valid_i, bus_busy_i, dma_busy_i, debug_busy_i;
  logic sw_periph_gate_i, lf_out_en_i, fast_xtal_track_i, fast_crystal_reference_ok_i, bank_we_i;
  logic mode_req_ack_o, main_system_clock_xtal_o, slow_system_clock_o, slow_clk_pin_o, slow_clk_pin_oe_n_o;
  logic rtc_clear_o, sys_reset_o;
  logic [2:0] slow_src, reset_cause_o;
  logic [25:0] sd_wake_mask_i, pin_level_i, gpio_out_i, gpio_oe_n_i, pad_out_o, pad_oe_n_o;
  logic [31:0] bank_wdata_i, bank_o;
  pmcm_req_type mode_req_i;
  pmcm_periph_type sw_periph_en_i, periph_o;
  pmcm_lfsel_type lf_sel_i;
  pmcm_wake_type wake_i;
  pmcm_state_type mode_o;
  pmcm_power_type power_o;
  int bad_count, comparisons;
  pmcm_top i_pmcm_top (.clk_sys_i, .rst_i, .por_i, .thermal_rst_i, .mode_req_valid_i, .mode_req_i,
    .bus_busy_i, .dma_busy_i, .debug_busy_i, .sw_periph_en_i, .sw_periph_gate_i, .lf_out_en_i, .lf_sel_i,
    .fast_xtal_track_i, .fast_crystal_reference_ok_i, .wake_i, .sd_wake_mask_i, .pin_level_i, .gpio_out_i,
    .gpio_oe_n_i, .bank_we_i, .bank_wdata_i, .slow_rc_oscillator_i(slow_src[0]),
    .slow_crystal_source_i(slow_src[1]), .slow_bypass_i(slow_src[2]), .mode_req_ack_o, .mode_o, .power_o,
    .periph_o, .main_system_clock_xtal_o, .slow_system_clock_o, .slow_clk_pin_o, .slow_clk_pin_oe_n_o,
    .rtc_clear_o, .sys_reset_o, .reset_cause_o, .pad_out_o, .pad_oe_n_o, .bank_o);
  pmcm_far_model i_pmcm_far_model (.clk_sys_i, .wake_o(wake_i), .pin_level_o(pin_level_i), .slow_src_o(slow_src));
  // clock
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // comparisons
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_mode(input pmcm_state_type got, input pmcm_state_type exp);
    chk_val({26'h0, got}, {26'h0, exp});
  endtask
  task automatic wait_mode(input pmcm_state_type m);
    for (int n = 0; n < 40 && mode_o !== m; n++) @(negedge clk_sys_i);
    chk_mode(mode_o, m);
  endtask
  task automatic request(input pmcm_req_type m);
    @(negedge clk_sys_i);
    mode_req_i = m;
    mode_req_valid_i = 1'b1;
    for (int n = 0; n < 20 && mode_req_ack_o !== 1'b1; n++) @(negedge clk_sys_i);
    chk_val(mode_req_ack_o, 1'b1);
    mode_req_valid_i = 1'b0;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // scenarios
  task automatic t_causes();
    chk_mode(mode_o, PMCM_ST_ACTIVE);
    chk_val(reset_cause_o, PMCM_CAUSE_POR);
    thermal_rst_i = 1'b1;
    @(negedge clk_sys_i);
    thermal_rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk_val(reset_cause_o, PMCM_CAUSE_THERMAL);
    i_pmcm_far_model.wake(0);
    chk_val(sys_reset_o, 1'b1);
    chk_val(rtc_clear_o, 1'b1);
    @(negedge clk_sys_i);
    chk_val(reset_cause_o, PMCM_CAUSE_PIN);
    chk_val(sys_reset_o, 1'b0);
    por_i = 1'b1;
    @(negedge clk_sys_i);
    por_i = 1'b0;
    chk_val(reset_cause_o, PMCM_CAUSE_POR);
  endtask
  task automatic t_busy();
    for (int k = 1; k < 3; k++) begin
      {bus_busy_i, dma_busy_i} = k[1:0];
      mode_req_i = PMCM_REQ_STANDBY;
      mode_req_valid_i = 1'b1;
      repeat (8) @(negedge clk_sys_i);
      chk_val(mode_req_ack_o, 1'b0);
      chk_mode(mode_o, PMCM_ST_ACTIVE);
      {bus_busy_i, dma_busy_i, mode_req_valid_i} = 3'h0;
      @(negedge clk_sys_i);
    end
  endtask
  task automatic t_standby();
    logic [25:0] ctx;
    for (int b = 0; b < 4; b++) begin
      gpio_out_i = 26'h15A5A5A ^ 26'(b);
      ctx = gpio_out_i;
      request(PMCM_REQ_STANDBY);
      wait_mode(PMCM_ST_STANDBY);
      gpio_out_i = ~gpio_out_i;
      @(negedge clk_sys_i);
      chk_val(pad_out_o, 26'h15A5A5A ^ b);
      chk_val(periph_o.io_controller_en, 1'b1);
      i_pmcm_far_model.wake(b);
      wait_mode(PMCM_ST_ACTIVE);
      chk_val(sys_reset_o, 1'b0);
      gpio_out_i = ctx;
      @(negedge clk_sys_i);
      chk_val(pad_out_o, 26'h15A5A5A ^ b);
    end
  endtask
  task automatic t_shutdown();
    sd_wake_mask_i = 26'h0000008;
    bank_we_i = 1'b1;
    bank_wdata_i = 32'hC0DE1234;
    @(negedge clk_sys_i);
    bank_we_i = 1'b0;
    gpio_out_i = 26'h2C3C3C3;
    gpio_oe_n_i = 26'h0F0F0F0;
    request(PMCM_REQ_SHUTDOWN);
    wait_mode(PMCM_ST_SHUTDOWN);
    gpio_out_i = 26'h0;
    gpio_oe_n_i = 26'h3FFFFFF;
    i_pmcm_far_model.flip(5);
    repeat (4) @(negedge clk_sys_i);
    chk_mode(mode_o, PMCM_ST_SHUTDOWN);
    chk_val(pad_out_o, 26'h2C3C3C3);
    chk_val(pad_oe_n_o, 26'h0F0F0F0);
    i_pmcm_far_model.flip(3);
    wait_mode(PMCM_ST_WAKERST);
    chk_val(reset_cause_o, PMCM_CAUSE_SDWAKE);
    chk_val(rtc_clear_o, 1'b1);
    wait_mode(PMCM_ST_ACTIVE);
    chk_val(bank_o, 32'hC0DE1234);
  endtask
  task automatic t_idle_clocks();
    debug_busy_i = 1'b1;
    request(PMCM_REQ_IDLE);
    wait_mode(PMCM_ST_IDLE);
    chk_val(power_o.cpu_run, 1'b0);
    chk_val(power_o.infra_clk_on, 1'b1);
    chk_val(power_o.flash_on, 1'b1);
    mode_req_i = PMCM_REQ_ACTIVE;
    mode_req_valid_i = 1'b1;
    wait_mode(PMCM_ST_ACTIVE);
    mode_req_valid_i = 1'b0;
    lf_out_en_i = 1'b1;
    for (int s = 0; s < 3; s++) begin
      lf_sel_i = pmcm_lfsel_type'(s);
      repeat (3) @(negedge clk_sys_i);
      chk_val(slow_clk_pin_oe_n_o, s == 2);
      chk_val(slow_system_clock_o, slow_src[s]);
      chk_val(slow_clk_pin_o, slow_src[s] && s != 2);
    end
    sw_periph_en_i.radio_en = 1'b1;
    for (int k = 0; k < 2; k++) begin
      {fast_xtal_track_i, fast_crystal_reference_ok_i} = {2{k[0]}};
      repeat (3) @(negedge clk_sys_i);
      chk_val(periph_o.radio_en, k[0]);
      chk_val(main_system_clock_xtal_o, k[0]);
    end
  endtask
  // watchdog: the whole run needs well under 1500 cycles
  initial begin
    #(25 * 4000);
    bad_count++;
    wrap_up();
  end
  // main sequence
  initial begin
    {rst_i, por_i, thermal_rst_i, mode_req_valid_i, bus_busy_i, dma_busy_i, debug_busy_i} = 7'h40;
    {sw_periph_gate_i, lf_out_en_i, fast_xtal_track_i, fast_crystal_reference_ok_i, bank_we_i} = 5'h0;
    {sd_wake_mask_i, gpio_out_i, gpio_oe_n_i, bank_wdata_i} = '0;
    mode_req_i = PMCM_REQ_ACTIVE;
    sw_periph_en_i = '0;
    lf_sel_i = PMCM_LF_RC;
    bad_count = 0;
    comparisons = 0;
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    t_causes();
    t_busy();
    t_standby();
    t_shutdown();
    t_idle_clocks();
    wrap_up();
  end
endmodule
`default_nettype wire
